// *** dv/irs_dev.sv ***
// Behavioural target model: reset pulse detector and startup timer.
// Assumes rst_n comes from the host sequencer on the same system clock.
`timescale 1ns/1ns
module irs_dev #(
	parameter int DET       = 8,
	parameter int WAIT      = 200,
	parameter int WAIT_LONG = 240
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic nvm,
	output logic      ready,
	output logic      seen,
	output logic      dev_oe
);
	int low = 0;
	int cnt = 0;
	assign dev_oe = 1'b0;
	always @(posedge clock) begin
		if (!rst_n) begin
			low <= low + 1;
			seen <= 1'b0;
			ready <= 1'b0;
			cnt <= 0;
		end else begin
			if (low > 0)
				seen <= (low >= DET);
			low <= 0;
			cnt <= cnt + 1;
			ready <= (cnt >= (nvm ? WAIT_LONG : WAIT));
		end
	end
endmodule : irs_dev

// *** dv/tb_top.sv ***
// Bench for irs_seq: random warm resets against a target model.
// Assumes short counts set through the design's parameters.
`timescale 1ns/1ns
module tb_top;
	import irs_pkg::*;
	logic clock = 0, link_clk = 0, srst = 1, warm_req = 0, nvm_pending = 0, link_busy = 0;
	logic sda_out, sda_oe, scl_out, scl_oe, rst_n_out, bus_ready, link_ready, seq_busy;
	logic dev_ready, dev_seen, dev_oe;
	wire  sda = ~((sda_oe & ~sda_out) | dev_oe);
	wire  scl = ~(scl_oe & ~scl_out);
	int   num_errors = 0;
	int   checked = 0;
	int   n;
	always #2 clock = ~clock;
	always begin
		#7 link_clk = ~link_clk;
		#8 link_clk = ~link_clk;
	end
	irs_seq #(.READY_CYC(200), .READY_LONG_CYC(240), .LOW_CYC(20), .LOW_MAX_CYC(100)) i_irs_seq (
		.clock, .srst, .link_clk, .warm_req, .nvm_pending, .link_busy, .sda_in(sda), .scl_in(scl),
		.sda_out, .sda_oe, .scl_out, .scl_oe, .rst_n_out, .bus_ready, .link_ready, .seq_busy);
	irs_dev i_irs_dev (.clock, .rst_n(rst_n_out), .nvm(nvm_pending), .ready(dev_ready), .seen(dev_seen),
		.dev_oe);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	function automatic int exp_wait(input logic nvm);
		return nvm ? 240 : 200;
	endfunction : exp_wait
	task give_verdict;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		#100000;
		num_errors++;
		give_verdict();
	end
	initial begin
		void'($urandom(32'h9489));
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		n = 0;
		while (bus_ready !== 1'b1 && n < 400) begin
			n++;
			@(posedge clock);
			#1;
		end
		chk(n >= 200, 1);
		chk({rst_n_out, seq_busy}, 2'h2);
		for (int i = 0; i < 5; i++) begin
			@(posedge clock);
			nvm_pending <= (i == 0) ? 1'b1 : 1'($urandom);
			link_busy <= 1'b1;
			warm_req <= 1'b1;
			@(posedge clock);
			warm_req <= 1'b0;
			@(posedge clock);
			#1 chk({bus_ready, seq_busy}, 2'h1);
			repeat ($urandom_range(12, 3)) begin
				@(posedge clock);
				#1 chk(rst_n_out, 1);
			end
			@(posedge clock);
			link_busy <= 1'b0;
			n = 0;
			while (rst_n_out !== 1'b0 && n < 50) begin
				n++;
				@(posedge clock);
				#1;
			end
			chk({sda, scl}, 2'b11);
			n = 0;
			while (rst_n_out === 1'b0 && n < 200) begin
				n++;
				@(posedge clock);
				#1;
			end
			chk(n, 20);
			n = 0;
			while (bus_ready !== 1'b1 && n < 400) begin
				n++;
				// A request in mid-wait must be ignored.
				warm_req <= (n == 50);
				@(posedge clock);
				#1;
			end
			chk(n >= exp_wait(nvm_pending) && n <= exp_wait(nvm_pending) + 2, 1);
			chk(dev_seen, 1);
			chk(rst_n_out, 1);
			repeat (4) @(posedge link_clk);
			#1 chk({link_ready, dev_ready, sda_oe, scl_oe, sda_out, scl_out, seq_busy}, 7'h60);
		end
		give_verdict();
	end
endmodule : tb_top

// *** hw/irs_pkg.sv ***
// Constants for the host-side startup and warm-reset sequencer of an I2C target.
// Assumes a 250 MHz system clock and a separate link clock for the bus-facing logic.
package irs_pkg;
	localparam int CLK_MHZ                  = 250;
	localparam int BUS_KHZ_MAX              = 1000;
	localparam int READY_WAIT_TIME_MS       = 10;
	localparam int READY_WAIT_LONG_MS       = 12;
	localparam int RESET_DETECT_MIN_TIME_US = 10;
	localparam int RESET_LOW_MAX_TIME_US    = 2500;
	localparam int READY_WAIT_CYC           = READY_WAIT_TIME_MS * 1000 * CLK_MHZ;
	localparam int READY_WAIT_LONG_CYC      = READY_WAIT_LONG_MS * 1000 * CLK_MHZ;
	localparam int RESET_LOW_MIN_CYC        = RESET_DETECT_MIN_TIME_US * CLK_MHZ;
	localparam int RESET_LOW_MAX_CYC        = RESET_LOW_MAX_TIME_US * CLK_MHZ;
	localparam int RESET_LOW_DEF_CYC        = 2 * RESET_LOW_MIN_CYC;
	localparam int DRAIN_MIN_CYC            = 4;
	localparam int CNT_W                    = 32;
	typedef enum logic [2:0] {
		IRS_POWER = 3'b000,
		IRS_DRAIN = 3'b001,
		IRS_RST   = 3'b010,
		IRS_WAIT  = 3'b011,
		IRS_READY = 3'b100
	} irs_state_e;
endpackage : irs_pkg

// *** hw/irs_seq.sv ***
// Host sequencer: drives the target's active-low reset and gates bus use by time.
// Assumes the I2C engine runs on link_clk and reports link_busy; bus lines are open drain.
`timescale 1ns/1ns
module irs_seq
	import irs_pkg::*;
#(
	parameter int READY_CYC      = irs_pkg::READY_WAIT_CYC,
	parameter int READY_LONG_CYC = irs_pkg::READY_WAIT_LONG_CYC,
	parameter int LOW_CYC        = irs_pkg::RESET_LOW_DEF_CYC,
	parameter int LOW_MAX_CYC    = irs_pkg::RESET_LOW_MAX_CYC
) (
	input  wire logic clock,
	input  wire logic srst,
	input  wire logic link_clk,
	input  wire logic warm_req,
	input  wire logic nvm_pending,
	input  wire logic link_busy,
	input  wire logic sda_in,
	input  wire logic scl_in,
	output logic      sda_out,
	output logic      sda_oe,
	output logic      scl_out,
	output logic      scl_oe,
	output logic      rst_n_out,
	output logic      bus_ready,
	output logic      link_ready,
	output logic      seq_busy
);
	import irs_pkg::*;

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	logic [2:0] busy_sync_q, busy_sync_d;
	logic [2:0] sda_sync_q, sda_sync_d, scl_sync_q, scl_sync_d;
	logic       busy_q, busy_d, lines_high_q, lines_high_d;

	always_comb begin
		busy_sync_d = {busy_sync_q[1:0], link_busy};
		sda_sync_d  = {sda_sync_q[1:0], sda_in};
		scl_sync_d  = {scl_sync_q[1:0], scl_in};
		busy_d      = (busy_sync_q[2] == busy_sync_q[1]) ? busy_sync_q[2] : busy_q;
		lines_high_d = ((sda_sync_q[2] == sda_sync_q[1]) && (scl_sync_q[2] == scl_sync_q[1]))
			? (sda_sync_q[2] & scl_sync_q[2]) : lines_high_q;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			busy_sync_q  <= 3'h1;
			sda_sync_q   <= 3'h0;
			scl_sync_q   <= 3'h0;
			busy_q       <= 1'b1;
			lines_high_q <= 1'b0;
		end else begin
			busy_sync_q  <= busy_sync_d;
			sda_sync_q   <= sda_sync_d;
			scl_sync_q   <= scl_sync_d;
			busy_q       <= busy_d;
			lines_high_q <= lines_high_d;
		end
	end

	// ************************************************************
	// Sequencer
	// ************************************************************
	irs_state_e       st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d, wait_q, wait_d;
	logic             rst_n_q, rst_n_d, rdy_q, rdy_d;

	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q + 32'h0000_0001;
		wait_d  = wait_q;
		rst_n_d = rst_n_q;
		rdy_d   = 1'b0;
		case (st_q)
			IRS_POWER: begin
				if (cnt_q >= CNT_W'(READY_CYC)) begin
					st_d = IRS_READY;
				end
			end
			IRS_READY: begin
				rdy_d = 1'b1;
				if (warm_req) begin
					rdy_d = 1'b0;
					cnt_d = '0;
					st_d  = IRS_DRAIN;
				end
			end
			IRS_DRAIN: begin
				// A transfer that began just before the request needs a few cycles to reach busy_q.
				// Waiting here keeps reset from falling under a transfer the synchroniser has not shown yet.
				if ((cnt_q >= CNT_W'(DRAIN_MIN_CYC)) && !busy_q && lines_high_q) begin
					rst_n_d = 1'b0;
					cnt_d   = '0;
					st_d    = IRS_RST;
				end
			end
			IRS_RST: begin
				if (cnt_q >= CNT_W'(LOW_CYC - 1)) begin
					rst_n_d = 1'b1;
					cnt_d   = '0;
					wait_d  = nvm_pending ? CNT_W'(READY_LONG_CYC) : CNT_W'(READY_CYC);
					st_d    = IRS_WAIT;
				end
			end
			IRS_WAIT: begin
				if (cnt_q >= wait_q) begin
					st_d = IRS_READY;
				end
			end
			default: st_d = IRS_POWER;
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			st_q    <= IRS_POWER;
			cnt_q   <= '0;
			wait_q  <= '0;
			// The reset line idles high so the target runs its own startup from power-up.
			rst_n_q <= 1'b1;
			rdy_q   <= 1'b0;
		end else begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			wait_q  <= wait_d;
			rst_n_q <= rst_n_d;
			rdy_q   <= rdy_d;
		end
	end

	// ************************************************************
	// Outputs and crossing of ready to the link domain
	// ************************************************************
	logic seq_busy_q, seq_busy_d;
	logic [1:0] lrdy_q, lrdy_d;

	always_comb begin
		seq_busy_d = (st_d != IRS_READY);
		lrdy_d     = {lrdy_q[0], rdy_q};
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			seq_busy_q <= 1'b1;
		end else begin
			seq_busy_q <= seq_busy_d;
		end
	end

	always_ff @(posedge link_clk) begin
		lrdy_q <= lrdy_d;
	end

	assign sda_out    = 1'b0;
	assign sda_oe     = 1'b0;
	assign scl_out    = 1'b0;
	assign scl_oe     = 1'b0;
	assign rst_n_out  = rst_n_q;
	assign bus_ready  = rdy_q;
	assign link_ready = lrdy_q[1];
	assign seq_busy   = seq_busy_q;

	// ************************************************************
	// Properties of the startup and warm-reset sequences
	// ************************************************************

	a_rst_low_min : assert property (@(posedge clock) disable iff (srst)
		$fell(rst_n_q) |-> !rst_n_q [*8]) else $error("reset pulse too short");
	a_rst_low_max : assert property (@(posedge clock) disable iff (srst)
		(st_q == IRS_RST) |-> (cnt_q < CNT_W'(LOW_MAX_CYC))) else $error("reset held too long");
	a_wait_no_rdy : assert property (@(posedge clock) disable iff (srst)
		(st_q == IRS_WAIT) |-> !rdy_d && rst_n_q) else $error("ready during wait");
	a_fall_idle : assert property (@(posedge clock) disable iff (srst)
		$fell(rst_n_q) |-> $past(lines_high_q) && !$past(busy_q)) else $error("reset fell on busy bus");
	a_long_wait : assert property (@(posedge clock) disable iff (srst)
		(st_q == IRS_RST && st_d == IRS_WAIT && nvm_pending)
		|=> (wait_q == CNT_W'(READY_LONG_CYC))) else $error("short wait after pending write");
	a_power_wait : assert property (@(posedge clock) disable iff (srst)
		(st_q == IRS_POWER) |-> !rdy_q) else $error("ready before startup");

	// Named steps of a warm reset, each used by one of the properties below.
	sequence s_busy_drain;
		(st_q == IRS_DRAIN) && busy_q;
	endsequence
	sequence s_rst_end;
		(st_q == IRS_RST) && rst_n_d;
	endsequence

	a_drain_busy : assert property (@(posedge clock) disable iff (srst)
		s_busy_drain |=> rst_n_q) else $error("reset fell while link busy");
	a_drain_dwell : assert property (@(posedge clock) disable iff (srst)
		$fell(rst_n_q) |-> ($past(cnt_q) >= CNT_W'(DRAIN_MIN_CYC))) else $error("reset fell too soon");
	a_wait_rise : assert property (@(posedge clock) disable iff (srst)
		s_rst_end |=> rst_n_q && (st_q == IRS_WAIT) && (cnt_q == '0)) else $error("wait not started at rise");
	a_short_wait : assert property (@(posedge clock) disable iff (srst)
		(st_q == IRS_RST && st_d == IRS_WAIT && !nvm_pending)
		|=> (wait_q == CNT_W'(READY_CYC))) else $error("wrong wait without pending write");
	a_ready_state : assert property (@(posedge clock) disable iff (srst)
		rdy_q |-> (st_q == IRS_READY) && rst_n_q) else $error("ready outside ready state");
endmodule : irs_seq
